// *** rtl/afe_timing_pkg.sv ***
// constants and types shared by the sensor front-end timing block
// assumes a single 25 MHz system clock samples every pin
package afe_timing_pkg;
   // ==========================================
   // widths and depths
   localparam int WORD_W = 10;
   localparam int PIPE_DEPTH = 9;
   localparam int GAIN_W = 10;
   localparam int MID_GAIN_W = 9;
   localparam int GAIN_REGION_BIT = 9;

   // ==========================================
   // field positions and reset values
   localparam int POL_SAMPLE_BIT = 1;
   localparam int POL_CLAMP_BIT = 0;
   localparam logic [1:0] POL_RESET = 2'h0;
   localparam logic [1:0] CLAMP_SEL_RESET = 2'h0;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 10'h000;
   localparam logic [WORD_W-1:0] FLOOR_RESET = 10'h3FF;

   // ==========================================
   // black levels in output codes, midscale offset
   localparam logic [WORD_W-1:0] BLACK_SEL0 = 10'h020;
   localparam logic [WORD_W-1:0] BLACK_SEL1 = 10'h030;
   localparam logic [WORD_W-1:0] BLACK_SEL2 = 10'h040;
   localparam logic [WORD_W-1:0] BLACK_SEL3 = 10'h010;
   localparam logic [WORD_W-1:0] MID_OFFSET = 10'h200;
   localparam logic [WORD_W-1:0] WORD_MAX = 10'h3FF;
   localparam logic [10:0] UNITY_GAIN = 11'h400;

   // ==========================================
   // timing, for reference only: the far side keeps it
   localparam int CLK_PERIOD_NS = 40;
   localparam int INHIBIT_NS = 15;
   localparam int INHIBIT_CYCLES_RAW = (INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INHIBIT_CYCLES = (INHIBIT_CYCLES_RAW < 1) ? 1 : INHIBIT_CYCLES_RAW;

   typedef enum logic [1:0] {
      MODE_DIRECT = 2'b00,
      MODE_AUX = 2'b01,
      MODE_MIDSCALE = 2'b10,
      MODE_IMAGE = 2'b11
   } conv_mode_t;

   function automatic logic [WORD_W-1:0] black_level(input logic [1:0] sel);
      if (sel == 2'h0) begin
         black_level = BLACK_SEL0;
      end else if (sel == 2'h1) begin
         black_level = BLACK_SEL1;
      end else if (sel == 2'h2) begin
         black_level = BLACK_SEL2;
      end else begin
         black_level = BLACK_SEL3;
      end
   endfunction : black_level
endpackage : afe_timing_pkg

// *** rtl/pipe_if.sv ***
// carries conversion words from the sampler into the output chain
// assumes the producer drives advance as a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
interface pipe_if;
   import afe_timing_pkg::*;
   logic advance;
   logic [WORD_W-1:0] word_in;
   logic [WORD_W-1:0] word_out;
   modport feed(output advance, output word_in, input word_out);
   modport chain(input advance, input word_in, output word_out);
endinterface : pipe_if
`default_nettype wire

// *** rtl/pipe_chain.sv ***
// nine-stage output register chain, shifted once per conversion edge
// assumes advance is a single-cycle pulse on clk_sys
`timescale 1ns/1ps
`default_nettype none
module pipe_chain #(
   parameter int DEPTH = afe_timing_pkg::PIPE_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // word stream
   pipe_if.chain p
);
   import afe_timing_pkg::*;

   logic [WORD_W-1:0] stage [DEPTH];
   logic [WORD_W-1:0] next_stage [DEPTH];

   // ==========================================
   // shift chain
   always_comb begin
      next_stage = stage;
      if (p.advance) begin
         next_stage[0] = p.word_in;
         for (int i = 1; i < DEPTH; i++) begin
            next_stage[i] = stage[i-1];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            stage[i] <= '0;
         end
      end else begin
         stage <= next_stage;
      end
   end

   assign p.word_out = stage[DEPTH-1];

   // ==========================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_chain_latency: assert property (p.advance |=> p.word_out == $past(stage[DEPTH-2]))
      else $error("output word did not come from the stage before last");
   a_chain_hold: assert property (!p.advance |=> $stable(p.word_out))
      else $error("output word moved without a conversion edge");
endmodule : pipe_chain
`default_nettype wire

// *** rtl/sensor_sample_clamp_timing.sv ***
// sampling, clamping and gain control of an image-sensor front end
// assumes all pins, the conversion clock among them, are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
// Contract
// - in image mode the reference and pixel levels are caught on their sample rising edges.
// - each converted sample appears on the output bus nine conversion cycles after it was taken.
// - with input clamp and pixel blanking both active the clamp is applied and blanking ignored.
// - reference standby holds while the sleep pin is high.
// - a two-bit field sets sample and clamp pulse levels independently, 00 all active low.
// - in aux and direct modes the most negative input is clamped to the black level.
// - a two-bit field selects black level 32, 48, 64 or 16 codes and resets to 00.
// - in image mode the gain stage takes a full 10-bit gain code.
// - image gain codes 0 to 511 and 512 to 1023 form two separate regions.
// - in midscale mode the gain stage uses only 9 bits of the code.
module sensor_sample_clamp_timing (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // timing pulses from the generator
   input wire logic reference_sample_pulse,
   input wire logic signal_sample_pulse,
   input wire logic conversion_clock,
   input wire logic black_level_clamp_pulse,
   input wire logic input_clamp_pulse,
   input wire logic pixel_blank_pulse,
   input wire logic reference_sleep_pin,
   // configuration
   input wire logic [1:0] conv_mode_sel,
   input wire logic [1:0] polarity_sel,
   input wire logic [1:0] clamp_level_sel,
   input wire logic [afe_timing_pkg::GAIN_W-1:0] gain_code,
   // digitised analog input
   input wire logic [afe_timing_pkg::WORD_W-1:0] sensor_level,
   // results and status
   output logic [afe_timing_pkg::WORD_W-1:0] output_word_bus,
   output logic reference_standby,
   output logic gain_upper_region
);
   import afe_timing_pkg::*;

   // ==========================================
   // state
   conv_mode_t mode, next_mode;
   logic [1:0] pol, next_pol;
   logic [1:0] clamp_sel, next_clamp_sel;
   logic [GAIN_W-1:0] gain_cfg, next_gain_cfg;
   logic ref_prev, next_ref_prev;
   logic sig_prev, next_sig_prev;
   logic conv_prev, next_conv_prev;
   logic [WORD_W-1:0] ref_level, next_ref_level;
   logic [WORD_W-1:0] pix_level, next_pix_level;
   logic [WORD_W-1:0] floor_level, next_floor_level;
   logic signed [12:0] ob_offset, next_ob_offset;
   logic next_standby;
   logic next_gain_upper;

   // ==========================================
   // combinational terms
   logic ref_act, sig_act, ob_act, clamp_act, blank_act, blank_eff;
   logic ref_rise, sig_rise, conv_rise;
   logic [GAIN_W-1:0] gain_eff;
   logic [WORD_W-1:0] black, cds, held, result;
   logic [20:0] product;
   logic [10:0] amp;
   logic signed [12:0] offset, sum;

   pipe_if pipe ();

   pipe_chain #(
      .DEPTH(PIPE_DEPTH)
   ) u_chain (
      .clk_sys(clk_sys),
      .rst(rst),
      .p(pipe.chain)
   );

   // ==========================================
   // pulse levels and edges
   always_comb begin
      ref_act = pol[POL_SAMPLE_BIT] ? reference_sample_pulse : !reference_sample_pulse;
      sig_act = pol[POL_SAMPLE_BIT] ? signal_sample_pulse : !signal_sample_pulse;
      ob_act = pol[POL_CLAMP_BIT] ? black_level_clamp_pulse : !black_level_clamp_pulse;
      clamp_act = pol[POL_CLAMP_BIT] ? input_clamp_pulse : !input_clamp_pulse;
      // blanking has no polarity field of its own and is taken as active high
      blank_act = pixel_blank_pulse;
      blank_eff = blank_act && !clamp_act;
      ref_rise = ref_act && !ref_prev;
      sig_rise = sig_act && !sig_prev;
      conv_rise = conversion_clock && !conv_prev;
   end

   // ==========================================
   // next values
   always_comb begin
      next_mode = conv_mode_t'(conv_mode_sel);
      next_pol = polarity_sel;
      next_clamp_sel = clamp_level_sel;
      next_gain_cfg = gain_code;
      next_ref_prev = ref_act;
      next_sig_prev = sig_act;
      next_conv_prev = conversion_clock;
      next_ref_level = ref_level;
      next_pix_level = pix_level;
      next_floor_level = floor_level;
      next_ob_offset = ob_offset;
      next_standby = reference_sleep_pin;
      if (mode == MODE_MIDSCALE) begin
         gain_eff = {1'b0, gain_cfg[MID_GAIN_W-1:0]};
      end else begin
         gain_eff = gain_cfg;
      end
      next_gain_upper = (mode == MODE_IMAGE) && gain_cfg[GAIN_REGION_BIT];
      black = black_level(clamp_sel);
      if (mode == MODE_IMAGE) begin
         cds = (ref_level > pix_level) ? ref_level - pix_level : '0;
      end else if (mode == MODE_MIDSCALE) begin
         // the midscale input has no floor clamp; its level goes straight to the gain stage
         cds = sensor_level;
      end else begin
         cds = (sensor_level > floor_level) ? sensor_level - floor_level : '0;
      end
      // an active clamp forces the input to its reference, so blanking has nothing to add
      if (clamp_act || blank_eff || reference_standby) begin
         held = '0;
      end else begin
         held = cds;
      end
      // gain shape is a simple linear stand-in; the analog curve is not modelled
      product = 21'(held) * 21'(UNITY_GAIN + 11'(gain_eff));
      if (mode == MODE_DIRECT) begin
         amp = {1'b0, held};
      end else begin
         amp = product[20:10];
      end
      if (mode == MODE_IMAGE) begin
         offset = ob_offset;
      end else if (mode == MODE_MIDSCALE) begin
         offset = $signed({3'b000, MID_OFFSET});
      end else begin
         offset = $signed({3'b000, black});
      end
      sum = $signed({2'b00, amp}) + offset;
      if (sum < 0) begin
         result = '0;
      end else if (sum > $signed({3'b000, WORD_MAX})) begin
         result = WORD_MAX;
      end else begin
         result = sum[WORD_W-1:0];
      end
      if (conv_rise) begin
         if ((mode == MODE_AUX || mode == MODE_DIRECT) && sensor_level < floor_level) begin
            // the floor never rises again until reset; a drifting sync tip is not followed
            next_floor_level = sensor_level;
         end
         if (mode == MODE_IMAGE && ob_act) begin
            next_ob_offset = $signed({3'b000, black}) - $signed({2'b00, amp});
         end
      end
      if (!reference_standby && mode == MODE_IMAGE) begin
         if (ref_rise) begin
            next_ref_level = sensor_level;
         end
         if (sig_rise) begin
            next_pix_level = sensor_level;
         end
      end
   end

   assign pipe.advance = conv_rise;
   assign pipe.word_in = result;
   assign output_word_bus = pipe.word_out;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode <= MODE_IMAGE;
         pol <= POL_RESET;
         clamp_sel <= CLAMP_SEL_RESET;
         gain_cfg <= GAIN_RESET;
         // start as if active, so loading the polarity code cannot fake a rise
         ref_prev <= 1'b1;
         sig_prev <= 1'b1;
         conv_prev <= 1'b0;
         ref_level <= '0;
         pix_level <= '0;
         floor_level <= FLOOR_RESET;
         ob_offset <= '0;
         reference_standby <= 1'b0;
         gain_upper_region <= 1'b0;
      end else begin
         mode <= next_mode;
         pol <= next_pol;
         clamp_sel <= next_clamp_sel;
         gain_cfg <= next_gain_cfg;
         ref_prev <= next_ref_prev;
         sig_prev <= next_sig_prev;
         conv_prev <= next_conv_prev;
         ref_level <= next_ref_level;
         pix_level <= next_pix_level;
         floor_level <= next_floor_level;
         ob_offset <= next_ob_offset;
         reference_standby <= next_standby;
         gain_upper_region <= next_gain_upper;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_ref_edge;
      ref_rise && mode == MODE_IMAGE && !reference_standby;
   endsequence

   a_ref_capture: assert property (s_ref_edge |=> ref_level == $past(sensor_level))
      else $error("reference level not caught on sample edge");
   a_pix_capture: assert property (sig_rise && mode == MODE_IMAGE && !reference_standby
         |=> pix_level == $past(sensor_level))
      else $error("pixel level not caught on sample edge");
   a_clamp_wins: assert property (clamp_act && blank_act |-> !blank_eff && held == '0)
      else $error("blanking acted while input clamp was on");
   a_standby_freeze: assert property (reference_sleep_pin |=> reference_standby ##0
         (held == '0) ##1 $stable(ref_level))
      else $error("standby did not freeze the sampler");
   a_polarity_low: assert property (pol == 2'h0 |-> ref_act == !reference_sample_pulse
         && clamp_act == !input_clamp_pulse)
      else $error("code 00 did not make pulses active low");
   a_floor_track: assert property (conv_rise && mode == MODE_AUX
         |=> floor_level <= $past(sensor_level) && floor_level <= $past(floor_level))
      else $error("most negative level not tracked");
   a_black_sel: assert property (clamp_sel == 2'h3 |-> black == 10'h010)
      else $error("black level select 11 not 16 codes");
   a_gain_full: assert property (mode == MODE_IMAGE |-> gain_eff == gain_cfg)
      else $error("image gain lost code bits");
   a_gain_region: assert property (mode == MODE_IMAGE && gain_cfg >= 10'h200
         |=> gain_upper_region)
      else $error("upper gain region not flagged");
   a_gain_mid: assert property (mode == MODE_MIDSCALE |-> gain_eff[GAIN_W-1] == 1'b0)
      else $error("midscale gain used more than 9 bits");
endmodule : sensor_sample_clamp_timing
`default_nettype wire

// *** tb/timing_gen_model.sv ***
// behavioural timing generator: sample, clamp and conversion pulses, one pixel per call
// assumes one bench process calls pixel(); every pin changes at a falling edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module timing_gen_model
   import afe_timing_pkg::*;
(
   // clock and polarity code
   input wire logic clk_sys,
   input wire logic [1:0] pol,
   // pins towards the front end
   output logic reference_sample_pulse,
   output logic signal_sample_pulse,
   output logic conversion_clock,
   output logic black_level_clamp_pulse,
   output logic input_clamp_pulse,
   output logic [WORD_W-1:0] sensor_level
);
   logic ref_on = 1'b0;
   logic sig_on = 1'b0;
   logic blk_on = 1'b0;
   logic icl_on = 1'b0;
   // ==========================================
   // pin levels follow the polarity code
   assign reference_sample_pulse = ref_on ~^ pol[1];
   assign signal_sample_pulse = sig_on ~^ pol[1];
   assign black_level_clamp_pulse = blk_on ~^ pol[0];
   assign input_clamp_pulse = icl_on ~^ pol[0];
   initial begin
      conversion_clock = 1'b0;
      sensor_level = 10'h000;
   end
   // ==========================================
   // one pixel; clamps stay up across calls so a run of calls makes one long pulse
   task automatic pixel(input logic [9:0] r, input logic [9:0] p, input logic blk,
                        input logic icl);
      @(negedge clk_sys);
      sensor_level = r;
      ref_on = 1'b1;
      blk_on = blk;
      icl_on = icl;
      @(negedge clk_sys);
      sensor_level = p;
      sig_on = 1'b1;
      @(negedge clk_sys);
      // two cycles after the reference rise, before the reference fall
      conversion_clock = 1'b1;
      @(negedge clk_sys);
      ref_on = 1'b0;
      sig_on = 1'b0;
      conversion_clock = 1'b0;
   endtask : pixel
endmodule : timing_gen_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the sensor front-end timing block
// assumes the timing generator model drives every pulse pin but pixel blanking, and the sensor level
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import afe_timing_pkg::*;
   logic clk_sys;
   logic rst;
   logic pixel_blank_pulse;
   logic reference_sleep_pin;
   logic [1:0] conv_mode_sel;
   logic [1:0] polarity_sel;
   logic [1:0] clamp_level_sel;
   logic [GAIN_W-1:0] gain_code;
   wire logic reference_sample_pulse;
   wire logic signal_sample_pulse;
   wire logic conversion_clock;
   wire logic black_level_clamp_pulse;
   wire logic input_clamp_pulse;
   wire logic [WORD_W-1:0] sensor_level;
   logic [WORD_W-1:0] output_word_bus;
   logic reference_standby;
   logic gain_upper_region;
   int fail_count = 0;
   int n_tests = 0;
   int floor_m;
   int ob_m;
   int blk_tab[4] = '{32, 48, 64, 16};
   logic [9:0] q[$];

   sensor_sample_clamp_timing i_dut (.clk_sys, .rst, .reference_sample_pulse,
      .signal_sample_pulse, .conversion_clock, .black_level_clamp_pulse, .input_clamp_pulse,
      .pixel_blank_pulse, .reference_sleep_pin, .conv_mode_sel, .polarity_sel,
      .clamp_level_sel, .gain_code, .sensor_level, .output_word_bus, .reference_standby,
      .gain_upper_region);
   timing_gen_model i_gen (.clk_sys, .pol(polarity_sel), .reference_sample_pulse,
      .signal_sample_pulse, .conversion_clock, .black_level_clamp_pulse, .input_clamp_pulse,
      .sensor_level);

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ==========================================
   // shared tasks
   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      n_tests++;
      if (seen !== want) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   // config is applied while reset is held; the model state restarts with the design
   task automatic restart(input logic [1:0] md, input logic [1:0] pl, input logic [1:0] cl,
                          input logic [9:0] g);
      @(negedge clk_sys);
      rst = 1'b1;
      conv_mode_sel = md;
      polarity_sel = pl;
      clamp_level_sel = cl;
      gain_code = g;
      q.delete();
      floor_m = 1023;
      ob_m = 0;
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask : restart
   // one pixel, its expected word, and the word due nine conversions back
   task automatic send(input logic [9:0] r, input logic [9:0] p, input logic blk,
                       input logic icl, input logic zin);
      int held;
      int v;
      int k;
      i_gen.pixel(r, p, blk, icl);
      if (conv_mode_sel == MODE_IMAGE) begin
         held = (zin || r < p) ? 0 : int'(r) - int'(p);
         held = (held * (1024 + int'(gain_code))) >> 10;
         v = held + ob_m;
         if (blk) ob_m = blk_tab[clamp_level_sel] - held;
      end else if (conv_mode_sel == MODE_MIDSCALE) begin
         held = zin ? 0 : (int'(p) * (1024 + int'(gain_code[MID_GAIN_W-1:0]))) >> 10;
         v = 512 + held;
      end else begin
         held = (int'(p) > floor_m) ? int'(p) - floor_m : 0;
         if (int'(p) < floor_m) floor_m = int'(p);
         v = blk_tab[clamp_level_sel] + held;
      end
      v = (v < 0) ? 0 : ((v > 1023) ? 1023 : v);
      q.push_back(v[9:0]);
      k = q.size();
      check(output_word_bus, (k >= 9) ? q[k-9] : 10'h000);
   endtask : send
   // ==========================================
   // scenarios
   task automatic test_pol();
      for (int pl = 0; pl < 4; pl++) begin
         restart(MODE_IMAGE, pl[1:0], 2'h0, 10'h000);
         for (int i = 0; i < 10; i++) send(10'(300 + i * 7), 10'(100 + i * 3), 0, 0, 0);
      end
      $display("test_pol finished");
   endtask : test_pol
   task automatic test_gain();
      logic [9:0] gl[3] = '{10'h1FF, 10'h200, 10'h3FF};
      foreach (gl[j]) begin
         restart(MODE_IMAGE, 2'h3, 2'h0, gl[j]);
         check(gain_upper_region, gl[j][9]);
         for (int i = 0; i < 10; i++) send(10'h190, 10'(200 - i * 10), 0, 0, 0);
      end
      $display("test_gain finished");
   endtask : test_gain
   task automatic test_mid();
      restart(MODE_MIDSCALE, 2'h3, 2'h0, 10'h3FF);
      check(gain_upper_region, 1'b0);
      for (int i = 0; i < 10; i++) send(10'h000, 10'h100, 0, 0, 0);
      $display("test_mid finished");
   endtask : test_mid
   // a dip to 495 lowers the floor, so later 500 reads five codes above black
   task automatic test_floor();
      for (int m = 0; m < 2; m++) begin
         for (int cl = 0; cl < 4; cl++) begin
            restart(m ? MODE_AUX : MODE_DIRECT, 2'h3, cl[1:0], 10'h000);
            for (int i = 0; i < 16; i++) begin
               send(10'h000, (i == 5) ? 10'h1EF : 10'h1F4, 0, 0, 0);
            end
         end
      end
      $display("test_floor finished");
   endtask : test_floor
   task automatic test_obclamp();
      restart(MODE_IMAGE, 2'h3, 2'h1, 10'h000);
      for (int i = 0; i < 20; i++) send(10'h12C, 10'h064, i < 10, 0, 0);
      $display("test_obclamp finished");
   endtask : test_obclamp
   task automatic test_zero();
      restart(MODE_IMAGE, 2'h3, 2'h0, 10'h000);
      for (int i = 0; i < 3; i++) send(10'h12C, 10'h064, 0, 0, 0);
      @(negedge clk_sys);
      reference_sleep_pin = 1'b1;
      check(reference_standby, 1'b0);
      @(negedge clk_sys);
      check(reference_standby, 1'b1);
      for (int i = 0; i < 4; i++) send(10'h12C, 10'h064, 0, 0, 1);
      @(negedge clk_sys);
      reference_sleep_pin = 1'b0;
      // blanking is optional; driven here with the input clamp for seven pixels, then alone for two
      pixel_blank_pulse = 1'b1;
      for (int i = 0; i < 7; i++) send(10'h12C, 10'h064, 0, 1, 1);
      for (int i = 0; i < 2; i++) send(10'h12C, 10'h064, 0, 0, 1);
      @(negedge clk_sys);
      pixel_blank_pulse = 1'b0;
      for (int i = 0; i < 9; i++) send(10'h12C, 10'h064, 0, 0, 0);
      $display("test_zero finished");
   endtask : test_zero
   // ==========================================
   // verdict, watchdog and main sequence
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // tests take about 1200 cycles; allow well over ten times that
   initial begin
      #1_000_000;
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      rst = 1'b1;
      pixel_blank_pulse = 1'b0;
      reference_sleep_pin = 1'b0;
      conv_mode_sel = MODE_IMAGE;
      polarity_sel = 2'h0;
      clamp_level_sel = 2'h0;
      gain_code = 10'h000;
      test_pol();
      test_gain();
      test_mid();
      test_floor();
      test_obclamp();
      test_zero();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
